// ---- logic/raster_block_fill_copy_engine.sv ----
// raster_block_fill_copy_engine: line draw, block fill and block copy on a word memory
// assumes a same-clock memory port: request held until a one-cycle ack, read data with ack
//
// Function
// R1: completion clears go_bit to 0.
// R2: completion raises irq only while done_irq_allow is set.
// R3: software sets go_bit to 1 last, then waits.
// R4: an all-zero op_control write discards the operation.
// R5: software clears done_flag before a new copy.
// R6: source width is words in the first source line minus 1.
// R7: destination width is words in the first line minus 1.
// R8: destination height is line count minus 1.
// R9: each stride is the word distance between line starts.
// R10: each image starts at its word-aligned base address.
// R11: first_bit_pos and last_bit_pos locate first and last pixels.
// R12: fill writes foreground_value to every pixel.
// R13: solid_area_select picks fill; size 0x4 is 16 bpp; logic 0x1 is AND.
// R14: vector_draw_select picks lines; clear senses step down.
// R15: same_size_select makes source width equal destination width.
// R16: keyout_enable keeps pixels whose source matches the key.
// R17: mask and destination functions pick AND, OR or XOR.
// R18: direction bits set line and word counting direction.
// R19: overlap to a higher address runs right-to-left, bottom-to-top.
// R20: source and destination directions are always equal; the code steps each from its own direction bit.
// R21: backfill_select paints pattern-off pixels in background, else skips.
// R22: pixel starts are multiples of the pixel size.
// R23: go_bit is 1 while busy; new settings are ignored.
`timescale 1ns/1ps
`default_nettype none
module raster_block_fill_copy_engine (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 ctrl_wr_i,
    input  wire raster_pkg::op_ctrl_t ctrl_wdata_i,
    input  wire raster_pkg::geom_t    geom_i,
    output var  raster_pkg::op_ctrl_t ctrl_o,
    output logic                      go_bit_o,
    output logic                      irq_o,
    output logic                      mem_req_o,
    output logic                      mem_we_o,
    output logic [31:0]               mem_addr_o,
    output logic [31:0]               mem_wdata_o,
    input  wire logic [31:0]          mem_rdata_i,
    input  wire logic                 mem_ack_i
);

    // =====================================================================
    // helpers
    function automatic logic [5:0] pix_bits(input logic [3:0] cs);
        case (cs)
            raster_pkg::CSIZE_16: pix_bits = 6'd16;
            raster_pkg::CSIZE_24: pix_bits = 6'd24;
            raster_pkg::CSIZE_32: pix_bits = 6'd32;
            default:              pix_bits = 6'd8;
        endcase
    endfunction : pix_bits

    function automatic logic [31:0] repl(input logic [23:0] v, input logic [3:0] cs);
        case (cs)
            raster_pkg::CSIZE_16: repl = {v[15:0], v[15:0]};
            raster_pkg::CSIZE_8:  repl = {4{v[7:0]}};
            default:              repl = {8'h00, v};
        endcase
    endfunction : repl

    function automatic logic [31:0] apply(input logic [1:0] op, input logic [31:0] a,
                                          input logic [31:0] b);
        case (op)
            raster_pkg::LOGIC_AND: apply = a & b;
            raster_pkg::LOGIC_OR:  apply = a | b;
            raster_pkg::LOGIC_XOR: apply = a ^ b;
            default:               apply = a;
        endcase
    endfunction : apply

    // byte lanes of pixels that match the key are kept from the destination
    function automatic logic [31:0] key_write(input logic [31:0] s, input logic [23:0] k,
                                              input logic [3:0] cs);
        logic hit;
        key_write = '0;
        for (int i = 0; i < 4; i++) begin
            case (cs)
                raster_pkg::CSIZE_8:  hit = (s[8*i +: 8] == k[7:0]);
                raster_pkg::CSIZE_16: hit = (s[16*(i/2) +: 16] == k[15:0]);
                default:              hit = (s[23:0] == k);
            endcase
            key_write[8*i +: 8] = hit ? 8'h00 : 8'hFF;
        end
    endfunction : key_write

    localparam logic [11:0] XCNT0 = raster_pkg::XCNT_RST;

    // =====================================================================
    // state
    raster_pkg::state_t   state_r,    state_nxt;
    raster_pkg::op_ctrl_t ctrl_r,     ctrl_nxt;
    raster_pkg::geom_t    geom_r,     geom_nxt;
    logic [11:0]          x_cnt_r,    x_cnt_nxt;
    logic [10:0]          y_cnt_r,    y_cnt_nxt;
    logic [31:0]          dst_row_r,  dst_row_nxt;
    logic [31:0]          src_row_r,  src_row_nxt;
    logic [31:0]          dst_addr_r, dst_addr_nxt;
    logic [31:0]          src_addr_r, src_addr_nxt;
    logic [31:0]          src_data_r, src_data_nxt;
    logic [31:0]          dst_data_r, dst_data_nxt;
    logic [4:0]           bit_pos_r,  bit_pos_nxt;
    logic [11:0]          acc_x_r,    acc_x_nxt;
    logic [11:0]          acc_y_r,    acc_y_nxt;
    logic [3:0]           pat_r,      pat_nxt;
    logic                 req_r,      req_nxt;
    logic                 we_r,       we_nxt;
    logic [31:0]          addr_r,     addr_nxt;
    logic [31:0]          wdata_r,    wdata_nxt;
    logic                 irq_r,      irq_nxt;

    // =====================================================================
    // datapath: merged write word
    logic [5:0]  pix;
    logic [5:0]  last_hi;
    logic [31:0] edge_m;
    logic [31:0] val;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [11:0] src_w;
    logic [31:0] dst_stride_b;
    logic [31:0] src_stride_b;
    logic        pat_on;
    logic        line_mode;
    logic        copy_mode;

    always_comb begin
        pix          = pix_bits(ctrl_r.color_size);
        line_mode    = ctrl_r.vector_draw_select;
        copy_mode    = !ctrl_r.vector_draw_select && !ctrl_r.solid_area_select;
        src_w        = ctrl_r.same_size_select ? geom_r.dst_words_per_row   // R15
                                               : geom_r.src_words_per_row;  // R6
        dst_stride_b = {18'h0, geom_r.dst_stride, 2'b00};                   // R9
        src_stride_b = {18'h0, geom_r.src_stride, 2'b00};                   // R9
        pat_on       = geom_r.line_pattern[pat_r];
        last_hi      = 6'({1'b0, geom_r.last_bit_pos} + pix - 6'd1);
        edge_m       = '1;
        if (x_cnt_r == XCNT0)
            edge_m = edge_m & ({32{1'b1}} << geom_r.first_bit_pos);            // R11
        if (x_cnt_r == geom_r.dst_words_per_row && last_hi < 6'd31)
            edge_m = edge_m & ((32'h1 << (last_hi + 6'd1)) - 32'h1);          // R11
        if (line_mode) begin
            val   = apply(ctrl_r.fill_logic_select,
                          repl(pat_on ? geom_r.foreground_value
                                      : geom_r.background_value,            // R21
                               ctrl_r.color_size), dst_data_r);
            wmask = (pix == 6'd32) ? '1 : (((32'h1 << pix) - 32'h1) << bit_pos_r);
        end else if (ctrl_r.solid_area_select) begin
            val   = apply(ctrl_r.fill_logic_select,                          // R13 R17
                          repl(geom_r.foreground_value, ctrl_r.color_size),  // R12
                          dst_data_r);
            wmask = edge_m;
        end else begin
            val   = apply(ctrl_r.target_logic_select, src_data_r, dst_data_r); // R17
            wmask = edge_m;
            if (ctrl_r.keyout_enable)
                wmask = wmask & key_write(src_data_r, geom_r.key_pattern,
                                          ctrl_r.color_size);                 // R16
        end
        merged = (val & wmask) | (dst_data_r & ~wmask);
    end

    // =====================================================================
    // sequencer
    logic [11:0] sum_x;
    logic [11:0] sum_y;
    logic        cy_x;
    logic        cy_y;
    logic [5:0]  bp_up;

    always_comb begin
        state_nxt    = state_r;
        ctrl_nxt     = ctrl_r;
        geom_nxt     = geom_r;
        x_cnt_nxt    = x_cnt_r;
        y_cnt_nxt    = y_cnt_r;
        dst_row_nxt  = dst_row_r;
        src_row_nxt  = src_row_r;
        dst_addr_nxt = dst_addr_r;
        src_addr_nxt = src_addr_r;
        src_data_nxt = src_data_r;
        dst_data_nxt = dst_data_r;
        bit_pos_nxt  = bit_pos_r;
        acc_x_nxt    = acc_x_r;
        acc_y_nxt    = acc_y_r;
        pat_nxt      = pat_r;
        req_nxt      = req_r;
        we_nxt       = we_r;
        addr_nxt     = addr_r;
        wdata_nxt    = wdata_r;
        {cy_x, sum_x} = {1'b0, acc_x_r} + {1'b0, geom_r.line_inc_x};
        {cy_y, sum_y} = {1'b0, acc_y_r} + {1'b0, geom_r.line_inc_y};
        bp_up        = {1'b0, bit_pos_r} + pix;
        if (ctrl_wr_i) begin
            if (state_r == raster_pkg::ST_IDLE) begin
                ctrl_nxt           = ctrl_wdata_i;
                // software writes only clear done_flag; only ST_DONE sets it
                ctrl_nxt.done_flag = ctrl_r.done_flag & ctrl_wdata_i.done_flag;  // R5
                if (ctrl_wdata_i.go_bit) begin // R3
                    geom_nxt     = geom_i; // R23
                    x_cnt_nxt    = XCNT0;
                    y_cnt_nxt    = raster_pkg::YCNT_RST;
                    dst_row_nxt  = geom_i.dst_base_addr; // R10
                    src_row_nxt  = geom_i.src_base_addr; // R10
                    dst_addr_nxt = geom_i.dst_base_addr;
                    src_addr_nxt = geom_i.src_base_addr;
                    bit_pos_nxt  = geom_i.first_bit_pos; // R11
                    acc_x_nxt    = raster_pkg::ACC_INIT;
                    acc_y_nxt    = raster_pkg::ACC_INIT;
                    pat_nxt      = raster_pkg::PAT_RST;
                    state_nxt    = (!ctrl_wdata_i.vector_draw_select &&
                                    !ctrl_wdata_i.solid_area_select)
                                   ? raster_pkg::ST_RD_SRC : raster_pkg::ST_RD_DST;
                end
            end else if (ctrl_wdata_i == raster_pkg::CTRL_RST &&
                         state_r != raster_pkg::ST_DONE) begin
                // all-zero write discards the running operation
                ctrl_nxt  = raster_pkg::CTRL_RST; // R4
                req_nxt   = 1'b0;
                state_nxt = raster_pkg::ST_IDLE;
            end
        end
        if (ctrl_nxt == raster_pkg::CTRL_RST && state_nxt == raster_pkg::ST_IDLE) begin
        end else unique case (state_r)
            raster_pkg::ST_IDLE: begin
            end
            raster_pkg::ST_RD_SRC: begin
                if (!req_r) begin
                    req_nxt  = 1'b1;
                    we_nxt   = 1'b0;
                    addr_nxt = src_addr_r;
                end else if (mem_ack_i) begin
                    req_nxt      = 1'b0;
                    src_data_nxt = mem_rdata_i;
                    state_nxt    = raster_pkg::ST_RD_DST;
                end
            end
            raster_pkg::ST_RD_DST: begin
                if (line_mode && !pat_on && !ctrl_r.backfill_select) begin
                    state_nxt = raster_pkg::ST_NEXT; // R14 R21
                end else if (!req_r) begin
                    req_nxt  = 1'b1;
                    we_nxt   = 1'b0;
                    addr_nxt = dst_addr_r;
                end else if (mem_ack_i) begin
                    req_nxt      = 1'b0;
                    dst_data_nxt = mem_rdata_i;
                    state_nxt    = raster_pkg::ST_WR_DST;
                end
            end
            raster_pkg::ST_WR_DST: begin
                if (!req_r) begin
                    req_nxt   = 1'b1;
                    we_nxt    = 1'b1;
                    addr_nxt  = dst_addr_r;
                    wdata_nxt = merged;
                end else if (mem_ack_i) begin
                    req_nxt   = 1'b0;
                    we_nxt    = 1'b0;
                    state_nxt = raster_pkg::ST_NEXT;
                end
            end
            raster_pkg::ST_NEXT: begin
                if (line_mode) begin
                    if (x_cnt_r == geom_r.dst_words_per_row) begin
                        state_nxt = raster_pkg::ST_DONE;
                    end else begin
                        x_cnt_nxt = x_cnt_r + 12'h001;
                        pat_nxt   = (pat_r == geom_r.pattern_last) ? raster_pkg::PAT_RST
                                                                   : pat_r + 4'h1;
                        acc_x_nxt = sum_x;
                        acc_y_nxt = sum_y;
                        state_nxt = raster_pkg::ST_RD_DST;
                        if (cy_x && ctrl_r.dst_x_sense) begin                    // R14 R18
                            bit_pos_nxt = bp_up[5] ? raster_pkg::BITPOS_RST : bp_up[4:0];
                            if (bp_up[5])
                                dst_addr_nxt = dst_addr_r + raster_pkg::WORD_STEP;
                        end else if (cy_x) begin
                            bit_pos_nxt = 5'(({1'b0, bit_pos_r} < pix)
                                             ? (6'd32 - pix) : ({1'b0, bit_pos_r} - pix));
                            if ({1'b0, bit_pos_r} < pix)
                                dst_addr_nxt = dst_addr_r - raster_pkg::WORD_STEP;
                        end
                        if (cy_y)
                            dst_addr_nxt = ctrl_r.dst_y_sense                    // R14 R18
                                ? dst_addr_nxt + dst_stride_b : dst_addr_nxt - dst_stride_b;
                    end
                end else if (x_cnt_r == geom_r.dst_words_per_row) begin         // R7
                    if (y_cnt_r == geom_r.dst_row_count) begin                  // R8
                        state_nxt = raster_pkg::ST_DONE;
                    end else begin
                        y_cnt_nxt    = y_cnt_r + 11'h001;
                        x_cnt_nxt    = XCNT0;
                        dst_row_nxt  = ctrl_r.dst_y_sense ? dst_row_r + dst_stride_b
                                                          : dst_row_r - dst_stride_b; // R18
                        src_row_nxt  = ctrl_r.src_y_reverse ? src_row_r + src_stride_b
                                                            : src_row_r - src_stride_b;
                        dst_addr_nxt = dst_row_nxt;
                        src_addr_nxt = src_row_nxt;
                        state_nxt    = copy_mode ? raster_pkg::ST_RD_SRC
                                                 : raster_pkg::ST_RD_DST;
                    end
                end else begin
                    x_cnt_nxt    = x_cnt_r + 12'h001;
                    dst_addr_nxt = ctrl_r.dst_x_sense ? dst_addr_r + raster_pkg::WORD_STEP
                                                      : dst_addr_r - raster_pkg::WORD_STEP;
                    src_addr_nxt = ctrl_r.src_x_reverse ? src_addr_r + raster_pkg::WORD_STEP
                                                        : src_addr_r - raster_pkg::WORD_STEP;
                    // past the source width the last source word is reused
                    state_nxt    = (copy_mode && x_cnt_nxt <= src_w)            // R6
                                   ? raster_pkg::ST_RD_SRC : raster_pkg::ST_RD_DST;
                end
            end
            raster_pkg::ST_DONE: begin
                ctrl_nxt.go_bit    = 1'b0; // R1 R23
                ctrl_nxt.done_flag = 1'b1;
                state_nxt          = raster_pkg::ST_IDLE;
            end
            default: begin
                req_nxt   = 1'b0;
                state_nxt = raster_pkg::ST_IDLE;
            end
        endcase
        irq_nxt = ctrl_nxt.done_flag & ctrl_nxt.done_irq_allow;                 // R2
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r    <= raster_pkg::ST_IDLE;
            ctrl_r     <= raster_pkg::CTRL_RST;
            geom_r     <= raster_pkg::GEOM_RST;
            x_cnt_r    <= raster_pkg::XCNT_RST;
            y_cnt_r    <= raster_pkg::YCNT_RST;
            dst_row_r  <= raster_pkg::ADDR_RST;
            src_row_r  <= raster_pkg::ADDR_RST;
            dst_addr_r <= raster_pkg::ADDR_RST;
            src_addr_r <= raster_pkg::ADDR_RST;
            src_data_r <= raster_pkg::DATA_RST;
            dst_data_r <= raster_pkg::DATA_RST;
            bit_pos_r  <= raster_pkg::BITPOS_RST;
            acc_x_r    <= raster_pkg::ACC_INIT;
            acc_y_r    <= raster_pkg::ACC_INIT;
            pat_r      <= raster_pkg::PAT_RST;
            req_r      <= 1'b0;
            we_r       <= 1'b0;
            addr_r     <= raster_pkg::ADDR_RST;
            wdata_r    <= raster_pkg::DATA_RST;
            irq_r      <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            ctrl_r     <= ctrl_nxt;
            geom_r     <= geom_nxt;
            x_cnt_r    <= x_cnt_nxt;
            y_cnt_r    <= y_cnt_nxt;
            dst_row_r  <= dst_row_nxt;
            src_row_r  <= src_row_nxt;
            dst_addr_r <= dst_addr_nxt;
            src_addr_r <= src_addr_nxt;
            src_data_r <= src_data_nxt;
            dst_data_r <= dst_data_nxt;
            bit_pos_r  <= bit_pos_nxt;
            acc_x_r    <= acc_x_nxt;
            acc_y_r    <= acc_y_nxt;
            pat_r      <= pat_nxt;
            req_r      <= req_nxt;
            we_r       <= we_nxt;
            addr_r     <= addr_nxt;
            wdata_r    <= wdata_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign ctrl_o      = ctrl_r;
    assign go_bit_o    = ctrl_r.go_bit; // R23
    assign irq_o       = irq_r;
    assign mem_req_o   = req_r;
    assign mem_we_o    = we_r;
    assign mem_addr_o  = addr_r;
    assign mem_wdata_o = wdata_r;

endmodule : raster_block_fill_copy_engine
`default_nettype wire

// ---- logic/raster_pkg.sv ----
// raster_pkg: constants, states and carrier structs of the raster fill/copy/line engine
// assumes one clock domain; software fields arrive as plain ports
package raster_pkg;

    // =====================================================================
    // pixel depth codes and logic function codes
    localparam logic [3:0]  CSIZE_8      = 4'h2;
    localparam logic [3:0]  CSIZE_16     = 4'h4;
    localparam logic [3:0]  CSIZE_24     = 4'h6;
    localparam logic [3:0]  CSIZE_32     = 4'h8;
    localparam logic [1:0]  LOGIC_COPY   = 2'h0;
    localparam logic [1:0]  LOGIC_AND    = 2'h1;
    localparam logic [1:0]  LOGIC_OR     = 2'h2;
    localparam logic [1:0]  LOGIC_XOR    = 2'h3;

    // =====================================================================
    // stepping and reset values
    localparam logic [11:0] ACC_INIT     = 12'h800;
    localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
    localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;
    localparam logic [11:0] XCNT_RST     = 12'h000;
    localparam logic [10:0] YCNT_RST     = 11'h000;
    localparam logic [4:0]  BITPOS_RST   = 5'h00;
    localparam logic [3:0]  PAT_RST      = 4'h0;

    // =====================================================================
    // sequencer states, gray along the read/read/write/step path
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RD_SRC = 3'h1,
        ST_RD_DST = 3'h3,
        ST_WR_DST = 3'h2,
        ST_NEXT   = 3'h6,
        ST_DONE   = 3'h7
    } state_t;

    // =====================================================================
    // op_control image
    typedef struct packed {
        logic       go_bit;
        logic       done_irq_allow;
        logic       done_flag;
        logic       solid_area_select;
        logic       vector_draw_select;
        logic       same_size_select;
        logic       keyout_enable;
        logic       backfill_select;
        logic       src_x_reverse;
        logic       src_y_reverse;
        logic       dst_x_sense;
        logic       dst_y_sense;
        logic [3:0] color_size;
        logic [1:0] fill_logic_select;
        logic [1:0] target_logic_select;
    } op_ctrl_t;

    localparam op_ctrl_t CTRL_RST = '0;

    // geometry, colours and line settings
    typedef struct packed {
        logic [31:0] src_base_addr;
        logic [31:0] dst_base_addr;
        logic [11:0] src_words_per_row;
        logic [11:0] dst_words_per_row;
        logic [10:0] dst_row_count;
        logic [11:0] src_stride;
        logic [11:0] dst_stride;
        logic [4:0]  src_first_bit;
        logic [4:0]  first_bit_pos;
        logic [4:0]  last_bit_pos;
        logic [23:0] foreground_value;
        logic [23:0] background_value;
        logic [23:0] key_pattern;
        logic [11:0] line_inc_x;
        logic [11:0] line_inc_y;
        logic [15:0] line_pattern;
        logic [3:0]  pattern_last;
    } geom_t;

    localparam geom_t GEOM_RST = '0;

endpackage : raster_pkg

// ---- tb/raster_block_fill_copy_engine_assertions.sv ----
// checker for the raster engine ports
// assumes bind onto the engine top, one clock
`timescale 1ns/1ps
`default_nettype none
module raster_block_fill_copy_engine_assertions (
    input wire logic                 clk_i,
    input wire logic                 rst_b_i,
    input wire logic                 ctrl_wr_i,
    input wire raster_pkg::op_ctrl_t ctrl_wdata_i,
    input wire raster_pkg::op_ctrl_t ctrl_o,
    input wire logic                 go_bit_o,
    input wire logic                 irq_o,
    input wire logic                 mem_req_o,
    input wire logic                 mem_we_o,
    input wire logic [31:0]          mem_addr_o,
    input wire logic                 mem_ack_i
);
    // ==========================================================
    // properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence pend_s;
        mem_req_o && !mem_ack_i && !(ctrl_wr_i && ctrl_wdata_i == '0);
    endsequence
    req_hold_a: assert property (pend_s |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("request changed before ack");
    req_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o) else $error("no gap");
    irq_map_a: assert property (irq_o == (ctrl_o.done_flag && ctrl_o.done_irq_allow))
        else $error("irq mismatch");
    go_view_a: assert property (go_bit_o == ctrl_o.go_bit) else $error("go view");
    done_set_a: assert property ($fell(go_bit_o) |-> ctrl_o.done_flag || ctrl_o == '0)
        else $error("end without done");
    start_op_a: assert property (ctrl_wr_i && ctrl_wdata_i.go_bit && !go_bit_o |=> go_bit_o)
        else $error("no start");
    word_align_a: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
        else $error("unaligned");
    abort_op_a: assert property (go_bit_o && ctrl_wr_i && ctrl_wdata_i == '0
        |=> ctrl_o == '0 || ctrl_o.done_flag && !go_bit_o)
        else $error("abort ignored");
endmodule : raster_block_fill_copy_engine_assertions
`default_nettype wire

// ---- tb/frame_mem_model.sv ----
// word memory behind the engine, random ack delay
// assumes request held until ack
`timescale 1ns/1ps
`default_nettype none
module frame_mem_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o,
    output logic             ack_o
);
    logic [31:0] mem [0:255];
    int          wait_n = 0;
    int          seed   = 7;
    initial rdata_o = '0;
    initial ack_o = 1'b0;
    // ==========================================================
    // access; data toggles when not answering so stale values never match
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (wait_n == 0) begin
                ack_o <= 1'b1;
                if (we_i) mem[addr_i[9:2]] <= wdata_i;
                else rdata_o <= mem[addr_i[9:2]];
                wait_n = $unsigned($random(seed)) % 4;
            end else wait_n = wait_n - 1;
        end
    end
endmodule : frame_mem_model
`default_nettype wire

// ---- tb/raster_block_fill_copy_engine_bench.sv ----
// random fill and copy runs against a word memory model
// assumes design package compiled first
`timescale 1ns/1ps
`default_nettype none
module raster_block_fill_copy_engine_bench;
    logic clk_i = 0, rst_b_i = 0, ctrl_wr_i = 0, req, we, ack, irq_o, go_bit_o;
    logic [31:0] addr, wdat, rdat, ref_m [0:255], e;
    raster_pkg::op_ctrl_t ctrl_wdata_i = '0, ctrl_o, c;
    raster_pkg::geom_t geom_i = '0, g;
    int miscompares = 0, n_checks = 0, seed = 7, w, h, d, s, k, y, x;
    raster_block_fill_copy_engine i_raster_block_fill_copy_engine (.clk_i, .rst_b_i, .ctrl_wr_i,
        .ctrl_wdata_i, .geom_i, .ctrl_o, .go_bit_o, .irq_o, .mem_req_o(req), .mem_we_o(we),
        .mem_addr_o(addr), .mem_wdata_o(wdat), .mem_rdata_i(rdat), .mem_ack_i(ack));
    frame_mem_model i_frame_mem_model (.clk_i, .req_i(req), .we_i(we), .addr_i(addr),
        .wdata_i(wdat), .rdata_o(rdat), .ack_o(ack));
    initial forever #20 clk_i = ~clk_i;
    // ==========================================================
    // helpers
    task automatic close_out;
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input raster_pkg::op_ctrl_t v);
        @(posedge clk_i) begin ctrl_wr_i <= 1'b1; ctrl_wdata_i <= v; end
        @(posedge clk_i) ctrl_wr_i <= 1'b0;
        #1;
    endtask : wr
    function automatic logic [31:0] fexp(logic [31:0] dw, logic [23:0] f, logic [1:0] m, logic b);
        logic [31:0] p;
        p = b ? {2{f[15:0]}} : {4{f[7:0]}};
        case (m)
            2'h1: return dw & p;
            2'h2: return dw | p;
            2'h3: return dw ^ p;
            default: return p;
        endcase
    endfunction : fexp
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int it = 0; it < 12; it++) begin
            w = $unsigned($random(seed)) % 3; h = $unsigned($random(seed)) % 3;
            d = 64 + $unsigned($random(seed)) % 32; s = $unsigned($random(seed)) % 32;
            for (k = 0; k < 256; k++) begin ref_m[k] = $random(seed); i_frame_mem_model.mem[k] = ref_m[k]; end
            g = '{dst_base_addr: d * 4, src_base_addr: s * 4, dst_words_per_row: w,
                src_words_per_row: w, dst_row_count: h, dst_stride: 8, src_stride: 8,
                foreground_value: $random(seed), last_bit_pos: it[2] ? 5'h10 : 5'h18, default: '0};
            c = '{go_bit: 1'b1, done_irq_allow: it[0], solid_area_select: it < 8,
                same_size_select: 1'b1, src_x_reverse: 1'b1, src_y_reverse: 1'b1, dst_x_sense: 1'b1,
                dst_y_sense: 1'b1, color_size: it[2] ? raster_pkg::CSIZE_16 : raster_pkg::CSIZE_8,
                fill_logic_select: it[1:0], default: '0};
            geom_i <= g;
            wr('0);
            wr(c);
            chk(go_bit_o, 1'b1);
            if (it == 11) begin
                repeat (3) @(posedge clk_i);
                wr('0);
                chk(go_bit_o, 1'b0);
                chk(irq_o, 1'b0);
                break;
            end
            for (k = 0; k < 3000 && go_bit_o !== 1'b0; k++) @(posedge clk_i) #1;
            if (k == 3000) begin miscompares++; break; end
            chk(irq_o, it[0]);
            for (y = 0; y <= h + 1; y++) for (x = 0; x <= w + 1; x++) begin
                k = d + y * 8 + x;
                e = (x > w || y > h) ? ref_m[k] : it < 8 ? fexp(ref_m[k], g.foreground_value,
                    it[1:0], it[2]) : ref_m[s + y * 8 + x];
                chk(i_frame_mem_model.mem[k], e);
            end
            wr('0);
            chk(ctrl_o.done_flag, 1'b0);
        end
        close_out();
    end
endmodule : raster_block_fill_copy_engine_bench
bind raster_block_fill_copy_engine raster_block_fill_copy_engine_assertions i_chk (.clk_i, .rst_b_i,
    .ctrl_wr_i, .ctrl_wdata_i, .ctrl_o, .go_bit_o, .irq_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_ack_i);
`default_nettype wire
